// File: inc/adc_seq_map.svh
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// Register byte offsets
`define OFS_CTRL0        8'h00
`define OFS_CTRL1        8'h04
`define OFS_CTRL2        8'h08
`define OFS_STATUS       8'h0C
`define OFS_MASK         8'h10
`define OFS_RESULT_BASE  8'h20
`define OFS_RESULT_LAST  8'h3C

// adc_control_zero fields
`define C0_CHAN          2:0
`define C0_SWEEP_MODE    3
`define C0_TRIG          4
`define C0_START         5
// adc_control_one fields
`define C1_SWEEP         1:0
`define C1_RES10         2
`define C1_LADDER        3
// adc_control_two fields
`define C2_SMP           0
`define C2_GROUP         2:1
// Status and mask fields
`define ST_DONE          0
`define ST_BUSY          8
// Result word address bits
`define RES_IDX          4:2

// Conversion lengths in conversion-clock cycles
`define CYC_SH_8         6'h1C
`define CYC_SH_10        6'h21
`define CYC_NOSH_8       6'h2F
`define CYC_NOSH_10      6'h38

// Misc constants
`define SWEEP_FIRST_IDX  2'h1
`define POS_ZERO         3'h0
`define UPPER_PAD        2'h0
`define RES_WIDTH        10

`endif

// File: inc/adc_seq_pkg.sv
package adc_seq_pkg;

   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV} seq_state_e;

   // Analog multiplexer selection
   typedef struct packed {
      logic [1:0] group;
      logic [2:0] pos;
   } input_sel_s;

   // Conversion timer state
   typedef struct packed {
      logic [5:0] cnt;
      logic       busy;
      logic       done;
   } timer_state_s;

   // Result memory state
   typedef struct packed {
      logic [9:0] rdata;
   } mem_state_s;

   // Sequencer and register file state
   typedef struct packed {
      seq_state_e  state;
      logic [2:0]  chan;
      logic        sweep_mode;
      logic        trig;
      logic        start;
      logic [1:0]  sweep;
      logic        res10;
      logic        ladder;
      logic        sample_hold_enable;
      logic [1:0]  group;
      logic        done_sts;
      logic        done_mask;
      logic        irq;
      logic        prev_trig;
      logic        phase;
      logic [1:0]  idx;
      input_sel_s  sel;
      logic        conv_go;
      logic        abort;
      logic        wr_en;
      logic [2:0]  wr_addr;
      logic [9:0]  wr_data;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        active;
   } seq_state_s;

endpackage : adc_seq_pkg

// File: core/adc_result_mem.sv
`timescale 1ns/1ns
`include "adc_seq_map.svh"

module adc_result_mem (
   // Clock and reset
   input  wire logic       clock_in,
   input  wire logic       rst_b_in,
   // Write port
   input  wire logic       wr_en_in,
   input  wire logic [2:0] wr_addr_in,
   input  wire logic [9:0] wr_data_in,
   // Read port
   input  wire logic [2:0] rd_addr_in,
   output logic [9:0]      rd_data_out
);

   adc_seq_pkg::mem_state_s r_reg;
   adc_seq_pkg::mem_state_s r_next;
   logic [9:0]              mem [0:7];

   // Storage has no reset, like the result registers it models
   always_ff @(posedge clock_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   // Read data always comes from a register
   always_comb begin
      r_next       = r_reg;
      r_next.rdata = mem[rd_addr_in];
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign rd_data_out = r_reg.rdata;

endmodule : adc_result_mem

// File: core/adc_conv_timer.sv
`timescale 1ns/1ns
`include "adc_seq_map.svh"

module adc_conv_timer (
   // Clock and reset
   input  wire logic clock_in,
   input  wire logic rst_b_in,
   // Control
   input  wire logic go_in,
   input  wire logic abort_in,
   input  wire logic res10_in,
   input  wire logic smp_in,
   // Status
   output logic      busy_out,
   output logic      done_out
);

   adc_seq_pkg::timer_state_s r_reg;
   adc_seq_pkg::timer_state_s r_next;

   // Cycles per input; sample-and-hold shortens the conversion
   function automatic logic [5:0] conv_len(input logic res10, input logic sample_hold_enable);
      if (sample_hold_enable) begin
         conv_len = res10 ? `CYC_SH_10 : `CYC_SH_8;
      end else begin
         conv_len = res10 ? `CYC_NOSH_10 : `CYC_NOSH_8;
      end
   endfunction : conv_len

   // Done pulses exactly conv_len cycles after go
   always_comb begin
      r_next      = r_reg;
      r_next.done = 1'b0;
      if (abort_in) begin
         r_next.busy = 1'b0;
      end else if (go_in) begin
         r_next.busy = 1'b1;
         r_next.cnt  = conv_len(res10_in, smp_in) - 6'h1;
      end else if (r_reg.busy) begin
         if (r_reg.cnt == 6'h1) begin
            r_next.busy = 1'b0;
            r_next.done = 1'b1;
         end
         r_next.cnt = r_reg.cnt - 6'h1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign busy_out = r_reg.busy;
   assign done_out = r_reg.done;

endmodule : adc_conv_timer

// File: core/adc_sequencer_control.sv
// Operation
// - One-shot mode converts the selected input exactly once, then finishes.
// - Software trigger: writing start bit one begins conversion.
// - Hardware trigger: trigger pin falling edge after start set begins conversion.
// - One-shot ends on completion; software trigger clears start bit itself.
// - Writing start bit zero halts; only stop for repeat sweep mode.
// - One-shot completion raises interrupt; repeat sweep raises none.
// - Channel field plus group field pick one input in one-shot.
// - Each result lands in the result register of its input position.
// - Repeat sweep interleaves input zero: 0,1,0,2,0,3, forever.
// - Sweep field picks first one to four inputs of the group.
// - Any group may be swept, all inputs from that one group.
// - Ten-bit mode stores bits 9..0; eight-bit mode bits 9..2.
// - With sample-and-hold, 28 cycles at 8 bits, 33 at 10 bits.
// - Ladder connect zero cuts the reference ladder, no current flows.
// - Ten-bit mode upper byte gives two top bits; eight-bit reads zero.
`timescale 1ns/1ns
`include "adc_seq_map.svh"

module adc_sequencer_control (
   // Clock and reset
   input  wire logic                      clock_in,
   input  wire logic                      rst_b_in,
   // APB slave
   input  wire logic                      psel_in,
   input  wire logic                      penable_in,
   input  wire logic                      pwrite_in,
   input  wire logic [7:0]                paddr_in,
   input  wire logic [31:0]               pwdata_in,
   output logic [31:0]                    prdata_out,
   output logic                           pready_out,
   output logic                           pslverr_out,
   // Interrupt
   output logic                           irq_out,
   // Analog front end
   input  wire logic [9:0]                conv_code_in,
   input  wire logic                      external_trigger_pin_in,
   output adc_seq_pkg::input_sel_s        input_sel_out,
   output logic                           sample_hold_enable_out,
   output logic                           ladder_connect_out,
   output logic                           conversion_active_out
);

   adc_seq_pkg::seq_state_s r_reg;
   adc_seq_pkg::seq_state_s r_next;
   logic [9:0]              mem_rdata;
   logic                    tmr_done;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // True for any offset that the register map decodes
   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == `OFS_CTRL0) || (a == `OFS_CTRL1) || (a == `OFS_CTRL2) ||
                    (a == `OFS_STATUS) || (a == `OFS_MASK) ||
                    ((a >= `OFS_RESULT_BASE) && (a <= `OFS_RESULT_LAST) &&
                     (a[1:0] == 2'h0));
   endfunction : addr_mapped

   // Result registers sit in one aligned word range
   function automatic logic is_result(input logic [7:0] a);
      is_result = (a >= `OFS_RESULT_BASE) && (a <= `OFS_RESULT_LAST);
   endfunction : is_result

   ////////////////////////////////////////////////////////////////////////////
   // Submodules

   // Result registers, one per input position
   adc_result_mem u_mem (
      .clock_in    (clock_in),
      .rst_b_in    (rst_b_in),
      .wr_en_in    (r_reg.wr_en),
      .wr_addr_in  (r_reg.wr_addr),
      .wr_data_in  (r_reg.wr_data),
      .rd_addr_in  (paddr_in[`RES_IDX]),
      .rd_data_out (mem_rdata)
   );

   // Per-input conversion length
   adc_conv_timer u_tmr (
      .clock_in (clock_in),
      .rst_b_in (rst_b_in),
      .go_in    (r_reg.conv_go),
      .abort_in (r_reg.abort),
      .res10_in (r_reg.res10),
      .smp_in   (r_reg.sample_hold_enable),
      .busy_out (),
      .done_out (tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic access;
      logic wr_fire;
      logic trig_fall;
      logic done_set;
      logic [9:0] stored;
      access    = psel_in && penable_in;
      wr_fire   = access && r_reg.pready && pwrite_in;
      trig_fall = r_reg.prev_trig && !external_trigger_pin_in;
      done_set  = 1'b0;
      stored    = '0;

      r_next           = r_reg;
      r_next.conv_go   = 1'b0;
      r_next.abort     = 1'b0;
      r_next.wr_en     = 1'b0;
      r_next.prev_trig = external_trigger_pin_in;

      // Answer in the second access cycle; read data taken one cycle early
      r_next.pready = access && !r_reg.pready;
      if (access && !r_reg.pready) begin
         r_next.prdata  = '0;
         r_next.pslverr = !addr_mapped(paddr_in);
         // Misaligned result offsets are refused and read zero
         if (is_result(paddr_in) && addr_mapped(paddr_in)) begin
            r_next.prdata[9:0] = mem_rdata;
         end else begin
            unique case (paddr_in)
               `OFS_CTRL0: begin
                  r_next.prdata[`C0_CHAN]       = r_reg.chan;
                  r_next.prdata[`C0_SWEEP_MODE] = r_reg.sweep_mode;
                  r_next.prdata[`C0_TRIG]       = r_reg.trig;
                  r_next.prdata[`C0_START]      = r_reg.start;
               end
               `OFS_CTRL1: begin
                  r_next.prdata[`C1_SWEEP]  = r_reg.sweep;
                  r_next.prdata[`C1_RES10]  = r_reg.res10;
                  r_next.prdata[`C1_LADDER] = r_reg.ladder;
               end
               `OFS_CTRL2: begin
                  r_next.prdata[`C2_SMP]   = r_reg.sample_hold_enable;
                  r_next.prdata[`C2_GROUP] = r_reg.group;
               end
               `OFS_STATUS: begin
                  r_next.prdata[`ST_DONE] = r_reg.done_sts;
                  r_next.prdata[`ST_BUSY] = (r_reg.state != adc_seq_pkg::ST_IDLE);
               end
               `OFS_MASK: r_next.prdata[`ST_DONE] = r_reg.done_mask;
               default: r_next.prdata = '0;
            endcase
         end
      end else if (!access) begin
         r_next.pslverr = 1'b0;
      end

      // Sequencer
      unique case (r_reg.state)
         adc_seq_pkg::ST_IDLE: begin
         end
         adc_seq_pkg::ST_ARMED: begin
            if (trig_fall) begin
               r_next.state   = adc_seq_pkg::ST_CONV;
               r_next.conv_go = 1'b1;
            end
         end
         adc_seq_pkg::ST_CONV: begin
            if (tmr_done) begin
               // Eight-bit results keep the top eight bits of the code
               stored = r_reg.res10 ? conv_code_in
                                    : {`UPPER_PAD, conv_code_in[9:2]};
               r_next.wr_en   = 1'b1;
               r_next.wr_addr = r_reg.sel.pos;
               r_next.wr_data = stored;
               if (r_reg.sweep_mode) begin
                  // Start stays set; the sweep only ends on a software halt
                  r_next.conv_go = 1'b1;
                  if (!r_reg.phase) begin
                     if (r_reg.sweep != 2'h0) begin
                        r_next.phase   = 1'b1;
                        r_next.sel.pos = {1'b0, r_reg.idx};
                     end
                  end else begin
                     r_next.phase   = 1'b0;
                     r_next.sel.pos = `POS_ZERO;
                     r_next.idx     = (r_reg.idx == r_reg.sweep) ? `SWEEP_FIRST_IDX
                                                                 : r_reg.idx + 2'h1;
                  end
               end else begin
                  r_next.state = adc_seq_pkg::ST_IDLE;
                  done_set     = 1'b1;
                  if (!r_reg.trig) begin
                     r_next.start = 1'b0;
                  end
               end
            end
         end
         default: r_next.state = adc_seq_pkg::ST_IDLE;
      endcase

      // Register writes; software wins over the hardware clear of start
      if (wr_fire) begin
         unique case (paddr_in)
            `OFS_CTRL0: begin
               r_next.chan       = pwdata_in[`C0_CHAN];
               r_next.sweep_mode = pwdata_in[`C0_SWEEP_MODE];
               r_next.trig       = pwdata_in[`C0_TRIG];
               r_next.start      = pwdata_in[`C0_START];
               if (!pwdata_in[`C0_START]) begin
                  r_next.state = adc_seq_pkg::ST_IDLE;
                  r_next.abort = 1'b1;
                  r_next.conv_go = 1'b0;
                  r_next.wr_en = 1'b0;
               end else if (r_reg.state == adc_seq_pkg::ST_IDLE) begin
                  // Selection is latched here; the group holds for the whole run, the position too in one-shot
                  r_next.sel.group = r_reg.group;
                  r_next.phase     = 1'b0;
                  r_next.idx       = `SWEEP_FIRST_IDX;
                  r_next.sel.pos   = pwdata_in[`C0_SWEEP_MODE] ? `POS_ZERO
                                                               : pwdata_in[`C0_CHAN];
                  if (pwdata_in[`C0_TRIG]) begin
                     r_next.state = adc_seq_pkg::ST_ARMED;
                  end else begin
                     r_next.state   = adc_seq_pkg::ST_CONV;
                     r_next.conv_go = 1'b1;
                  end
               end
            end
            `OFS_CTRL1: begin
               r_next.sweep  = pwdata_in[`C1_SWEEP];
               r_next.res10  = pwdata_in[`C1_RES10];
               r_next.ladder = pwdata_in[`C1_LADDER];
            end
            `OFS_CTRL2: begin
               r_next.sample_hold_enable   = pwdata_in[`C2_SMP];
               r_next.group = pwdata_in[`C2_GROUP];
            end
            `OFS_STATUS: begin
               if (pwdata_in[`ST_DONE]) begin
                  r_next.done_sts = 1'b0;
               end
            end
            `OFS_MASK: r_next.done_mask = pwdata_in[`ST_DONE];
            default: begin
            end
         endcase
      end

      // A completion in the clearing cycle is kept
      if (done_set) begin
         r_next.done_sts = 1'b1;
      end
      r_next.irq = r_next.done_sts && r_next.done_mask;
      // Registered so the busy indication is glitch free at the pin
      r_next.active = (r_next.state == adc_seq_pkg::ST_CONV);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         r_reg           <= '0;
         r_reg.state     <= adc_seq_pkg::ST_IDLE;
         r_reg.prev_trig <= 1'b1; // Avoid a false edge just after reset
         r_reg.idx       <= `SWEEP_FIRST_IDX;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all from the state register

   assign prdata_out             = r_reg.prdata;
   assign pready_out             = r_reg.pready;
   assign pslverr_out            = r_reg.pslverr;
   assign irq_out                = r_reg.irq;
   assign input_sel_out          = r_reg.sel;
   assign sample_hold_enable_out = r_reg.sample_hold_enable;
   // Ladder is cut whenever the bit is clear, saving reference current
   assign ladder_connect_out     = r_reg.ladder;
   assign conversion_active_out  = r_reg.active;

endmodule : adc_sequencer_control

// File: tb/adc_seq_sva.sv
`timescale 1ns/1ns
`include "adc_seq_map.svh"

module adc_seq_sva (
   // Clock, reset and bus
   input wire logic              clock_in,
   input wire logic              rst_b_in,
   input wire logic              psel_in,
   input wire logic              penable_in,
   input wire logic              pwrite_in,
   input wire logic [7:0]        paddr_in,
   input wire logic [31:0]       pwdata_in,
   input wire logic              pready_out,
   input wire logic              irq_out,
   // Front end
   input wire logic              external_trigger_pin_in,
   input adc_seq_pkg::input_sel_s input_sel_out,
   input wire logic              ladder_connect_out,
   input wire logic              conversion_active_out
);
   logic       wr_ok;
   logic       sweep_reg;
   logic       trig_reg;
   logic [1:0] scnt_reg;

   assign wr_ok = psel_in && penable_in && pready_out && pwrite_in;

   // Shadow of mode bits, since the checker cannot see the registers
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         sweep_reg <= 1'b0;
         trig_reg  <= 1'b0;
         scnt_reg  <= 2'h0;
      end else if (wr_ok && paddr_in == `OFS_CTRL0) begin
         sweep_reg <= pwdata_in[`C0_SWEEP_MODE];
         trig_reg  <= pwdata_in[`C0_TRIG];
      end else if (wr_ok && paddr_in == `OFS_CTRL1) begin
         scnt_reg  <= pwdata_in[`C1_SWEEP];
      end
   end

   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);

   sequence c0_wr; wr_ok && paddr_in == `OFS_CTRL0; endsequence
   sequence c1_wr; wr_ok && paddr_in == `OFS_CTRL1; endsequence

   ladder_cut_a: assert property (
      c1_wr ##0 !pwdata_in[`C1_LADDER] |-> ##[1:2] !ladder_connect_out) else $error("ladder kept");
   halt_a: assert property (
      c0_wr ##0 !pwdata_in[`C0_START] |-> ##[1:2] !conversion_active_out) else $error("no halt");
   sw_go_a: assert property (
      c0_wr ##0 (pwdata_in[`C0_START] && !pwdata_in[`C0_TRIG] && !conversion_active_out)
      |-> ##[1:2] conversion_active_out) else $error("no software start");
   no_irq_sweep_a: assert property (
      sweep_reg |-> !$rose(irq_out)) else $error("irq in sweep");
   sel_hold_a: assert property (
      !sweep_reg && conversion_active_out && $past(conversion_active_out)
      |-> $stable(input_sel_out)) else $error("select moved");
   grp_hold_a: assert property (
      conversion_active_out && $past(conversion_active_out)
      |-> $stable(input_sel_out.group)) else $error("group moved");
   zero_step_a: assert property (
      sweep_reg && conversion_active_out && $past(conversion_active_out)
      && $changed(input_sel_out.pos)
      |-> (input_sel_out.pos == 3'h0) != ($past(input_sel_out.pos) == 3'h0))
      else $error("zero not interleaved");
   pos_range_a: assert property (
      sweep_reg && conversion_active_out && $past(conversion_active_out)
      |-> input_sel_out.pos <= {1'b0, scnt_reg}) else $error("pos out of sweep");
   hw_edge_a: assert property (
      trig_reg && $rose(conversion_active_out)
      |-> !$past(external_trigger_pin_in) && $past(external_trigger_pin_in, 4))
      else $error("start without falling edge");
endmodule : adc_seq_sva

// File: tb/adc_front_model.sv
`timescale 1ns/1ns

module adc_front_model (
   // Clock and mux select
   input wire logic              clock_in,
   input adc_seq_pkg::input_sel_s sel_in,
   input wire logic              ladder_in,
   // Trigger request from the bench
   input wire logic              fire_in,
   // Code and trigger pin
   output logic [9:0]            code_out,
   output logic                  trig_pin_out
);
   logic [1:0] low_reg  = 2'h0;
   logic [9:0] junk_reg = 10'h2AA;

   // Pin held low three cycles per request; junk toggles so no stale code looks valid
   always_ff @(posedge clock_in) begin
      junk_reg <= ~junk_reg;
      low_reg  <= fire_in ? 2'h3 : (low_reg != 2'h0 ? low_reg - 2'h1 : 2'h0);
   end

   // Code depends on group and pin, so a wrong mux select shows in the result
   assign code_out     = ladder_in ? {sel_in.group, sel_in.pos, 5'h15} : junk_reg;
   assign trig_pin_out = (low_reg == 2'h0);
endmodule : adc_front_model

// File: tb/adc_sequencer_control_test.sv
`timescale 1ns/1ns
`include "adc_seq_map.svh"

module adc_sequencer_control_test;
   logic                      clock_in = 1'b0;
   logic                      rst_b_in = 1'b0;
   logic                      psel_in, penable_in, pwrite_in;
   logic [7:0]                paddr_in;
   logic [31:0]               pwdata_in, prdata_out, rd;
   logic                      pready_out, pslverr_out, irq_out, err;
   logic [9:0]                code, e;
   logic                      pin, smp_o, lad_o, active, act_d;
   logic                      fire = 1'b0;
   logic                      logging = 1'b0;
   adc_seq_pkg::input_sel_s   sel, sel_d;
   logic [4:0]                log_q[$];
   logic [4:0]                first;
   logic [2:0]                chs[4] = '{3'h5, 3'h2, 3'h7, 3'h1};
   logic [1:0]                g;
   logic                      r, s;
   int                        errors = 0;
   int                        check_count = 0;
   int                        c, k;

   adc_sequencer_control i_dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .irq_out(irq_out), .conv_code_in(code),
      .external_trigger_pin_in(pin), .input_sel_out(sel), .sample_hold_enable_out(smp_o),
      .ladder_connect_out(lad_o), .conversion_active_out(active));
   adc_front_model i_front (.clock_in(clock_in), .sel_in(sel), .ladder_in(lad_o),
      .fire_in(fire), .code_out(code), .trig_pin_out(pin));

   initial forever #25 clock_in = ~clock_in;

   //////////////////////////////////////////////////
   task end_sim;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   // One APB transfer; request held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock_in);
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
      @(posedge clock_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clock_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      rd = prdata_out;
      err = pslverr_out;
      {psel_in, penable_in} <= 2'b00;
      if (n >= 20) chk(0, 1, "no pready");
   endtask : apb

   // Cycles of one run, and the select seen at its first cycle
   task conv_len;
      k = 0;
      c = 0;
      while (active !== 1'b1 && k < 50) begin
         @(posedge clock_in);
         k++;
      end
      first = sel;
      while (active === 1'b1 && c < 200) begin
         @(posedge clock_in);
         c++;
      end
   endtask : conv_len

   // Logs each new select of a sweep, to check order and group
   always @(posedge clock_in) begin
      if (logging && active === 1'b1 && (act_d !== 1'b1 || sel != sel_d)) log_q.push_back(sel);
      act_d <= active;
      sel_d <= sel;
   end

   //////////////////////////////////////////////////
   initial begin
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
      repeat (4) @(posedge clock_in);
      rst_b_in <= 1'b1;
      apb(0, 8'h40, 0);
      chk(err, 1, "unmapped refused");
      apb(1, `OFS_CTRL1, 32'h8);
      repeat (20) @(posedge clock_in);
      apb(1, `OFS_MASK, 1);
      // One-shot over every group, both resolutions
      for (int i = 0; i < 4; i++) begin
         g = i[1:0];
         r = !i[0];
         s = (i != 2);
         apb(1, `OFS_CTRL2, {29'h0, g, s});
         apb(1, `OFS_CTRL1, {28'h0, 1'b1, r, 2'h0});
         apb(1, `OFS_CTRL0, {26'h0, 3'b100, chs[i]});
         conv_len;
         chk(first, {g, chs[i]}, "mux select");
         chk(smp_o, s, "hold enable");
         if (s) chk(c >= (r ? 33 : 28) && c <= (r ? 35 : 30), 1, "length");
         repeat (3) @(posedge clock_in);
         chk(active, 0, "single run");
         chk(irq_out, 1, "done irq");
         apb(0, `OFS_CTRL0, 0);
         chk(rd, {26'h0, 3'b000, chs[i]}, "start cleared");
         e = {g, chs[i], 5'h15};
         apb(0, 8'h20 + {3'h0, chs[i], 2'h0}, 0);
         chk(rd, {22'h0, r ? e : {2'h0, e[9:2]}}, "result");
         apb(1, `OFS_MASK, 0);
         repeat (2) @(posedge clock_in);
         chk(irq_out, 0, "irq masked");
         apb(1, `OFS_STATUS, 1);
         apb(1, `OFS_MASK, 1);
         repeat (2) @(posedge clock_in);
         chk(irq_out, 0, "irq cleared");
      end
      // Hardware trigger waits for the falling edge
      apb(1, `OFS_CTRL2, 1);
      apb(1, `OFS_CTRL0, 32'h34);
      repeat (10) @(posedge clock_in);
      chk(active, 0, "armed idle");
      fire <= 1'b1;
      @(posedge clock_in);
      fire <= 1'b0;
      conv_len;
      chk(c > 0, 1, "edge start");
      repeat (3) @(posedge clock_in);
      chk(irq_out, 1, "hw irq");
      apb(0, `OFS_CTRL0, 0);
      chk(rd, 32'h34, "start kept");
      apb(1, `OFS_STATUS, 1);
      apb(1, `OFS_CTRL0, 0);
      // Repeat sweep of two and four pins
      for (int p = 1; p < 4; p += 2) begin
         g = p[1] ? 2'h2 : 2'h0;
         apb(1, `OFS_CTRL2, {29'h0, g, 1'b1});
         apb(1, `OFS_CTRL1, {28'h0, 2'b10, p[1:0]});
         log_q.delete();
         logging <= 1'b1;
         apb(1, `OFS_CTRL0, 32'h28);
         for (k = 0; k < 1000 && log_q.size() < 8; k++) @(posedge clock_in);
         apb(0, `OFS_CTRL0, 0);
         chk(rd, 32'h28, "start held");
         chk(irq_out, 0, "no sweep irq");
         apb(1, `OFS_CTRL0, 32'h08);
         logging <= 1'b0;
         repeat (3) @(posedge clock_in);
         chk(active, 0, "halted");
         for (int j = 0; j < 8; j++) chk(log_q[j], {g, j[0] ? 3'((j / 2) % p + 1) : 3'h0}, "order");
      end
      apb(1, `OFS_CTRL1, 0);
      repeat (3) @(posedge clock_in);
      chk(lad_o, 0, "ladder cut");
      end_sim;
   end

   // Watchdog well beyond the expected run
   initial begin
      #(50 * 30000);
      errors++;
      end_sim;
   end
endmodule : adc_sequencer_control_test

bind adc_sequencer_control adc_seq_sva i_sva (.clock_in(clock_in), .rst_b_in(rst_b_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .pready_out(pready_out), .irq_out(irq_out),
   .external_trigger_pin_in(external_trigger_pin_in), .input_sel_out(input_sel_out),
   .ladder_connect_out(ladder_connect_out), .conversion_active_out(conversion_active_out));
